// ===== src/ssq_pkg.sv
// Operation
// RULE1: Free-running mode: one start command keeps scans running until stopped.
// RULE2: Trigger mode: a start command acts as one trigger; one per scan.
// RULE3: Stop command lets the running conversion finish, then starts nothing.
// RULE4: Block stop halts conversions and powers the converter down.
// RULE5: End-of-conversion interrupt enable gates the interrupt request.
// RULE6: Sequenced done status is zero until all enabled channels converted.
// RULE7: Injection done status is zero until injection conversion finished.
// RULE8: Reading end-of-conversion status clears it after returning it.
// RULE9: Each channel has its own signed 16-bit result register.
// RULE10: Results indexed from zero; injection at index equal to channel count.
// RULE11: Channel enable mask selects scanned channels; unconfigured bits ignored.
// RULE12: Writing channel mask never enables the injection channel.
// RULE13: Injection enable adds injection to next scan only, then self-clears.
// RULE14: Software-writable low limit is the lower compare threshold.
// RULE15: Software-writable high limit is the upper compare threshold.
// RULE16: Per-channel limit mask gates limit events; unconfigured bits ignored.
// RULE17: Per-channel saturation mask gates saturation events likewise.
// RULE18: Saturation is a result of zero or the full-scale code.
// RULE19: Averaged channel: stay, take N readings, store right-aligned sum.
// RULE20: Trigger mode: outside logic gives a rising edge per scan.
// RULE21: Convert enabled channels ascending, then injection, then signal done.
package ssq_pkg;

  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------
  localparam logic [7:0] SSQ_ADDR_CTRL     = 8'h00;
  localparam logic [7:0] SSQ_ADDR_CMD      = 8'h04;
  localparam logic [7:0] SSQ_ADDR_STATUS   = 8'h08;
  localparam logic [7:0] SSQ_ADDR_CHMASK   = 8'h0c;
  localparam logic [7:0] SSQ_ADDR_LIMMASK  = 8'h10;
  localparam logic [7:0] SSQ_ADDR_SATMASK  = 8'h14;
  localparam logic [7:0] SSQ_ADDR_LOWLIM   = 8'h18;
  localparam logic [7:0] SSQ_ADDR_HIGHLIM  = 8'h1c;
  localparam logic [7:0] SSQ_ADDR_AVGMASK  = 8'h20;
  localparam logic [7:0] SSQ_ADDR_EVENTS   = 8'h24;
  localparam logic [7:0] SSQ_ADDR_RESULT0  = 8'h40;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  // CTRL: bit0 trigger mode, bit1 eoc irq enable, bit2 block enable.
  localparam int SSQ_CTRL_TRIG    = 0;
  localparam int SSQ_CTRL_IRQEN   = 1;
  localparam int SSQ_CTRL_ENABLE  = 2;
  // CMD (write only): bit0 start, bit1 stop, bit2 inject enable.
  localparam int SSQ_CMD_START    = 0;
  localparam int SSQ_CMD_STOP     = 1;
  localparam int SSQ_CMD_INJECT   = 2;
  // STATUS: bit0 seq done, bit1 inject done, bit2 busy, bit3 inject armed.
  localparam int SSQ_ST_SEQ_DONE  = 0;
  localparam int SSQ_ST_INJ_DONE  = 1;
  localparam int SSQ_ST_BUSY      = 2;
  localparam int SSQ_ST_INJ_ARMED = 3;

  localparam logic [31:0] SSQ_CTRL_RESET = 32'h0000_0004;
  localparam int          SSQ_RES_W      = 16;

endpackage

// ===== src/ssq_result_mem.sv
`timescale 1ns/1ns
// Result store: one signed word per channel, injection last.
module ssq_result_mem #(
  parameter int N_ENT = 9,
  parameter int AW    = 4
) (
  // Clock
  input  wire logic                  clock,
  // Write side
  input  wire logic                  wr_en,
  input  wire logic [AW-1:0]         wr_idx,
  input  wire logic signed [15:0]    wr_data,
  // Read side
  input  wire logic [AW-1:0]         rd_idx,
  output logic signed [15:0]         rd_data
);
  import ssq_pkg::*;

  logic signed [15:0] mem [N_ENT];

  // RULE9 signed result store
  always_ff @(posedge clock) begin
    if (wr_en && (int'(wr_idx) < N_ENT)) begin
      mem[wr_idx] <= wr_data;
    end
  end

  assign rd_data = (int'(rd_idx) < N_ENT) ? mem[rd_idx] : '0;
endmodule

// ===== src/ssq_top.sv
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ns
module ssq_top #(
  parameter int N_SEQ   = 8,
  parameter int RES_B   = 12,
  parameter int AVG_N   = 4
) (
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                rst,
  // Register port
  input  wire logic [7:0]          addr,
  input  wire logic [31:0]         wdata,
  input  wire logic                wr,
  input  wire logic                rd,
  output logic [31:0]              rdata,
  // Hardware trigger pin
  input  wire logic                scan_trigger,
  // Converter core
  output logic                     conv_start,
  output logic [3:0]               conv_chan,
  output logic                     conv_power,
  input  wire logic                conv_done,
  input  wire logic [15:0]         conv_data,
  // Interrupts out
  output logic                     eoc_irq,
  output logic                     limit_irq,
  output logic                     sat_irq
);
  import ssq_pkg::*;

  localparam int NT = N_SEQ + 1;
  localparam logic [3:0] INJ_IDX = 4'(N_SEQ);
  localparam logic [15:0] FULL_CODE = 16'((1 << RES_B) - 1);
  localparam logic [7:0] AVG_LAST = 8'(AVG_N - 1);

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef enum logic [2:0] {
    SSQ_IDLE, SSQ_PICK, SSQ_ISSUE, SSQ_WAIT, SSQ_STORE
  } ssq_fsm_type;

  typedef struct packed {
    ssq_fsm_type   fsm;
    logic          trig_mode;
    logic          irq_en;
    logic          enable;
    logic          running;
    logic          stop_req;
    logic          pend_trig;
    logic          inj_armed;
    logic          inj_in_scan;
    logic          seq_done;
    logic          inj_done;
    logic [7:0]    ch_mask;
    logic [7:0]    avg_mask;
    logic [NT-1:0] lim_mask;
    logic [NT-1:0] sat_mask;
    logic [15:0]   low_lim;
    logic [15:0]   high_lim;
    logic [NT-1:0] lim_ev;
    logic [NT-1:0] sat_ev;
    logic [3:0]    chan;
    logic [7:0]    avg_cnt;
    logic [23:0]   acc;
    logic [31:0]   rdata;
    logic          conv_start;
    logic          eoc_irq;
    logic          limit_irq;
    logic          sat_irq;
  } ssq_state_type;

  ssq_state_type s_reg;
  ssq_state_type s_next;

  logic               trig_pulse;
  logic signed [15:0] mem_rdata;
  logic               mem_we;
  logic [15:0]        sample;

  ssq_trig_sync u_sync (
    .clock      (clock),
    .rst        (rst),
    .pin_in     (scan_trigger),
    .rise_pulse (trig_pulse)
  );

  ssq_result_mem #(.N_ENT(NT), .AW(4)) u_mem (
    .clock   (clock),
    .wr_en   (mem_we),
    .wr_idx  (s_reg.chan),
    .wr_data (sample),
    .rd_idx  (4'(addr[5:2])),
    .rd_data (mem_rdata)
  );

  // First enabled sequenced channel at or above a given index.
  function automatic logic [3:0] next_chan(input logic [7:0] m,
                                           input logic [3:0] from);
    logic [3:0] r;
    r = INJ_IDX;
    for (int i = N_SEQ - 1; i >= 0; i--) begin
      if (m[i] && (i >= int'(from))) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction

  // Keep only the bits of configured channels.
  function automatic logic [7:0] cfg_only(input logic [31:0] v);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < N_SEQ; i++) begin
      r[i] = v[i];
    end
    return r;
  endfunction

  // RULE19 averaged sum is right-aligned
  // The core's data stand only beside conv_done, so the store always takes
  // the accumulator, which holds the single reading of a plain channel.
  assign sample = s_reg.acc[15:0];
  assign mem_we = (s_reg.fsm == SSQ_STORE);

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  always_comb begin
    logic start_cmd;
    logic stop_cmd;
    logic [3:0] nc;
    start_cmd = 1'b0;
    stop_cmd  = 1'b0;
    nc        = '0;
    s_next = s_reg;
    s_next.conv_start = 1'b0;

    // Register writes.
    if (wr) begin
      case (addr)
        SSQ_ADDR_CTRL: begin
          s_next.trig_mode = wdata[SSQ_CTRL_TRIG];
          // RULE5 irq enable bit
          s_next.irq_en    = wdata[SSQ_CTRL_IRQEN];
          s_next.enable    = wdata[SSQ_CTRL_ENABLE];
        end
        SSQ_ADDR_CMD: begin
          start_cmd = wdata[SSQ_CMD_START];
          stop_cmd  = wdata[SSQ_CMD_STOP];
          // RULE13 arm injection once
          if (wdata[SSQ_CMD_INJECT]) s_next.inj_armed = 1'b1;
        end
        // RULE11 RULE12 mask without injection
        SSQ_ADDR_CHMASK:  s_next.ch_mask  = cfg_only(wdata);
        SSQ_ADDR_AVGMASK: s_next.avg_mask = cfg_only(wdata);
        // RULE16 limit mask filtered
        SSQ_ADDR_LIMMASK: s_next.lim_mask = NT'({wdata[N_SEQ], cfg_only(wdata)});
        // RULE17 saturation mask filtered
        SSQ_ADDR_SATMASK: s_next.sat_mask = NT'({wdata[N_SEQ], cfg_only(wdata)});
        // RULE14 low limit
        SSQ_ADDR_LOWLIM:  s_next.low_lim  = wdata[15:0];
        // RULE15 high limit
        SSQ_ADDR_HIGHLIM: s_next.high_lim = wdata[15:0];
        SSQ_ADDR_EVENTS: begin
          s_next.lim_ev = s_reg.lim_ev & ~wdata[NT-1:0];
          s_next.sat_ev = s_reg.sat_ev & ~wdata[NT-1:0];
        end
        default: ;
      endcase
    end

    // Register reads: data stands in the following cycle.
    s_next.rdata = '0;
    if (rd) begin
      case (addr)
        SSQ_ADDR_CTRL: s_next.rdata = {29'h0, s_reg.enable, s_reg.irq_en,
                                       s_reg.trig_mode};
        SSQ_ADDR_STATUS: begin
          s_next.rdata[SSQ_ST_SEQ_DONE]  = s_reg.seq_done;
          s_next.rdata[SSQ_ST_INJ_DONE]  = s_reg.inj_done;
          s_next.rdata[SSQ_ST_BUSY]      = s_reg.running;
          s_next.rdata[SSQ_ST_INJ_ARMED] = s_reg.inj_armed;
          // RULE8 clear on read
          s_next.seq_done = 1'b0;
          s_next.inj_done = 1'b0;
        end
        SSQ_ADDR_CHMASK:  s_next.rdata = {24'h0, s_reg.ch_mask};
        SSQ_ADDR_AVGMASK: s_next.rdata = {24'h0, s_reg.avg_mask};
        SSQ_ADDR_LIMMASK: s_next.rdata = 32'(s_reg.lim_mask);
        SSQ_ADDR_SATMASK: s_next.rdata = 32'(s_reg.sat_mask);
        SSQ_ADDR_LOWLIM:  s_next.rdata = {16'h0, s_reg.low_lim};
        SSQ_ADDR_HIGHLIM: s_next.rdata = {16'h0, s_reg.high_lim};
        SSQ_ADDR_EVENTS:  s_next.rdata = {8'h0, 8'(s_reg.sat_ev), 8'h0,
                                          8'(s_reg.lim_ev)};
        // RULE10 result words, injection at index N_SEQ
        default: begin
          if (addr[7:6] == SSQ_ADDR_RESULT0[7:6])
            s_next.rdata = 32'(mem_rdata);
        end
      endcase
    end

    // RULE1 RULE2 start handling
    if (start_cmd && s_reg.enable) begin
      if (s_reg.trig_mode) s_next.pend_trig = 1'b1;
      else s_next.running = 1'b1;
      s_next.stop_req = 1'b0;
    end
    // RULE20 hardware trigger edge
    if (trig_pulse && s_reg.trig_mode && s_reg.enable) s_next.pend_trig = 1'b1;
    // RULE3 graceful stop
    if (stop_cmd) begin
      s_next.stop_req  = 1'b1;
      s_next.running   = 1'b0;
      s_next.pend_trig = 1'b0;
    end

    case (s_reg.fsm)
      SSQ_IDLE: begin
        if (s_reg.enable && !stop_cmd &&
            (s_reg.running || s_reg.pend_trig)) begin
          s_next.pend_trig   = 1'b0;
          s_next.stop_req    = 1'b0;
          s_next.inj_in_scan = s_reg.inj_armed;
          // RULE13 self clear when taken
          if (!(wr && addr == SSQ_ADDR_CMD && wdata[SSQ_CMD_INJECT]))
            s_next.inj_armed = 1'b0;
          s_next.chan = '0;
          s_next.fsm  = SSQ_PICK;
        end
      end
      SSQ_PICK: begin
        // RULE21 ascending then injection
        nc = (s_reg.chan == INJ_IDX) ? INJ_IDX
                                     : next_chan(s_reg.ch_mask, s_reg.chan);
        s_next.avg_cnt = '0;
        s_next.acc     = '0;
        if (nc == INJ_IDX && !s_reg.inj_in_scan) begin
          s_next.fsm = SSQ_IDLE;
          // RULE6 set wins over read clear
          s_next.seq_done = 1'b1;
          // RULE5 gated eoc irq
          s_next.eoc_irq = s_reg.irq_en;
          if (s_reg.trig_mode) s_next.running = 1'b0;
        end else if (s_reg.stop_req || stop_cmd) begin
          // RULE3 no new conversion after stop
          s_next.fsm = SSQ_IDLE;
        end else begin
          s_next.chan = nc;
          s_next.fsm  = SSQ_ISSUE;
        end
      end
      SSQ_ISSUE: begin
        s_next.conv_start = 1'b1;
        s_next.fsm        = SSQ_WAIT;
      end
      SSQ_WAIT: begin
        if (conv_done) begin
          s_next.acc = s_reg.acc + 24'(conv_data);
          // RULE19 stay on averaged channel
          if (s_reg.chan != INJ_IDX && s_reg.avg_mask[s_reg.chan[2:0]] &&
              s_reg.avg_cnt != AVG_LAST) begin
            s_next.avg_cnt = s_reg.avg_cnt + 8'h01;
            s_next.fsm     = SSQ_ISSUE;
          end else begin
            s_next.fsm = SSQ_STORE;
          end
        end
      end
      SSQ_STORE: begin
        // RULE14 RULE15 RULE16 limit compare
        if (s_reg.lim_mask[s_reg.chan] &&
            (sample < s_reg.low_lim || sample > s_reg.high_lim))
          s_next.lim_ev[s_reg.chan] = 1'b1;
        // RULE18 RULE17 saturation detect
        if (s_reg.sat_mask[s_reg.chan] &&
            (sample == '0 || sample == FULL_CODE))
          s_next.sat_ev[s_reg.chan] = 1'b1;
        if (s_reg.chan == INJ_IDX) begin
          // RULE7 injection done
          s_next.inj_done    = 1'b1;
          s_next.inj_in_scan = 1'b0;
          s_next.seq_done    = 1'b1;
          s_next.eoc_irq     = s_reg.irq_en;
          s_next.fsm         = SSQ_IDLE;
          if (s_reg.trig_mode) s_next.running = 1'b0;
        end else begin
          s_next.chan = s_reg.chan + 4'h1;
          s_next.fsm  = SSQ_PICK;
        end
      end
      default: s_next.fsm = SSQ_IDLE;
    endcase

    if (s_next.eoc_irq && !(s_reg.fsm == SSQ_PICK || s_reg.fsm == SSQ_STORE))
      s_next.eoc_irq = 1'b0;
    s_next.limit_irq = |s_next.lim_ev;
    s_next.sat_irq   = |s_next.sat_ev;

    // RULE4 block stop powers down
    if (!s_reg.enable) begin
      s_next.running   = 1'b0;
      s_next.pend_trig = 1'b0;
      if (s_reg.fsm != SSQ_WAIT) s_next.fsm = SSQ_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      s_reg          <= '0;
      s_reg.fsm      <= SSQ_IDLE;
      s_reg.enable   <= SSQ_CTRL_RESET[SSQ_CTRL_ENABLE];
      s_reg.high_lim <= '1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata      = s_reg.rdata;
  assign conv_start = s_reg.conv_start;
  assign conv_chan  = s_reg.chan;
  assign conv_power = s_reg.enable;
  assign eoc_irq    = s_reg.eoc_irq;
  assign limit_irq  = s_reg.limit_irq;
  assign sat_irq    = s_reg.sat_irq;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  property p_stop_no_start;
    @(posedge clock) disable iff (rst)
      (wr && addr == SSQ_ADDR_CMD && wdata[SSQ_CMD_STOP] &&
       s_reg.fsm == SSQ_IDLE) |=> !conv_start [*3];
  endproperty
  a_stop_no_start: assert property (p_stop_no_start) // RULE3
    else $error("conversion started after stop");

  property p_power_off;
    @(posedge clock) disable iff (rst)
      (wr && addr == SSQ_ADDR_CTRL && !wdata[SSQ_CTRL_ENABLE]) |=> !conv_power;
  endproperty
  a_power_off: assert property (p_power_off) // RULE4
    else $error("power stayed on after block stop");

  property p_irq_gated;
    @(posedge clock) disable iff (rst) eoc_irq |-> $past(s_reg.irq_en);
  endproperty
  a_irq_gated: assert property (p_irq_gated) // RULE5
    else $error("eoc irq while disabled");

  property p_irq_pulse;
    @(posedge clock) disable iff (rst) eoc_irq |=> !eoc_irq;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse) // RULE5
    else $error("eoc irq longer than one cycle");

  property p_done_clear;
    @(posedge clock) disable iff (rst)
      (rd && addr == SSQ_ADDR_STATUS && s_reg.fsm == SSQ_IDLE)
        |=> !s_reg.seq_done;
  endproperty
  a_done_clear: assert property (p_done_clear) // RULE8
    else $error("done not cleared by read");

  property p_mask_noinj;
    @(posedge clock) disable iff (rst)
      (wr && addr == SSQ_ADDR_CHMASK && !s_reg.inj_armed) |=> !s_reg.inj_armed;
  endproperty
  a_mask_noinj: assert property (p_mask_noinj) // RULE12
    else $error("channel mask armed injection");

  property p_inj_oneshot;
    @(posedge clock) disable iff (rst)
      (s_reg.fsm == SSQ_IDLE && s_next.fsm == SSQ_PICK &&
       !(wr && addr == SSQ_ADDR_CMD)) |=> !s_reg.inj_armed;
  endproperty
  a_inj_oneshot: assert property (p_inj_oneshot) // RULE13
    else $error("injection enable not self-cleared");

  property p_order;
    @(posedge clock) disable iff (rst)
      (s_reg.fsm == SSQ_STORE && s_reg.chan != INJ_IDX)
        |=> s_reg.chan == $past(s_reg.chan) + 4'h1;
  endproperty
  a_order: assert property (p_order) // RULE21
    else $error("channel order broken");

  property p_chan_enabled;
    @(posedge clock) disable iff (rst)
      (conv_start && conv_chan != INJ_IDX) |-> s_reg.ch_mask[conv_chan[2:0]];
  endproperty
  a_chan_enabled: assert property (p_chan_enabled) // RULE11
    else $error("disabled channel converted");
endmodule

// ===== src/ssq_trig_sync.sv
`timescale 1ns/1ns
// Two-stage synchroniser with rising-edge pulse on the second stage.
module ssq_trig_sync (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Pin and pulse
  input  wire logic pin_in,
  output logic      rise_pulse
);
  import ssq_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } ssq_sync_type;

  ssq_sync_type st_reg;
  ssq_sync_type st_next;

  always_comb begin
    st_next    = st_reg;
    st_next.s1 = pin_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rise_pulse = st_reg.s2 & ~st_reg.s3;
endmodule

// ===== verif/ssq_top_bench.sv
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("Error at %0t got %h expected %h", $time, (g), (e)); end end
module ssq_top_bench;
  import ssq_pkg::*;
  localparam int N_SEQ = 8;
  localparam int AVG   = 4;

  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic        scan_trigger = 1'b0;
  logic        conv_start;
  logic [3:0]  conv_chan;
  logic        conv_power;
  logic        conv_done = 1'b0;
  logic [15:0] conv_data = 16'h5a5a;
  logic        eoc_irq;
  logic        limit_irq;
  logic        sat_irq;
  logic [3:0]  chq[$];
  logic [3:0]  cur_chan = 4'h0;
  logic [31:0] v;
  logic [31:0] st;
  int          busy_cnt = 0;
  int          n_start = 0;
  int          n_done = 0;
  int          n_eoc = 0;
  int          e0;
  int          n;
  int          cycles = 0;
  int          n_fail = 0;
  int          compares = 0;

  ssq_top #(.N_SEQ(N_SEQ), .RES_B(12), .AVG_N(AVG)) uut (
    .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .scan_trigger(scan_trigger),
    .conv_start(conv_start), .conv_chan(conv_chan),
    .conv_power(conv_power), .conv_done(conv_done),
    .conv_data(conv_data), .eoc_irq(eoc_irq), .limit_irq(limit_irq),
    .sat_irq(sat_irq)
  );

  always #10 clock = ~clock;

  // -------------------------------------------------------------------
  // Converter core stand-in
  // -------------------------------------------------------------------
  // Channel 2 reads zero so that it saturates; channel 1 is negative.
  function automatic logic [15:0] chan_val(input logic [3:0] ch);
    case (ch)
      4'h1:    chan_val = 16'hff80;
      4'h2:    chan_val = 16'h0000;
      default: chan_val = 16'h0120 + {12'h000, ch};
    endcase
  endfunction

  // Idle data toggles every cycle so a stale sample never looks valid.
  always @(posedge clock) begin
    if (busy_cnt != 0) busy_cnt <= busy_cnt - 1;
    if (conv_start) begin
      busy_cnt <= 4;
      cur_chan <= conv_chan;
      chq.push_back(conv_chan);
      n_start <= n_start + 1;
    end
    if (busy_cnt == 1) begin
      conv_done <= 1'b1;
      conv_data <= chan_val(cur_chan);
      n_done <= n_done + 1;
    end else begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data;
    end
    if (eoc_irq) n_eoc <= n_eoc + 1;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      end_sim();
    end
  end

  // -------------------------------------------------------------------
  // Register port tasks
  // -------------------------------------------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Polling reads clear the done flags, so every read is accumulated.
  task automatic scan(input logic pin, output logic [31:0] s);
    logic [31:0] r;
    chq.delete();
    s = 32'h0000_0000;
    if (pin) begin
      @(posedge clock);
      scan_trigger <= 1'b1;
      repeat (4) @(posedge clock);
      scan_trigger <= 1'b0;
    end else begin
      wr_reg(SSQ_ADDR_CMD, 32'h1 << SSQ_CMD_START);
    end
    rd_reg(SSQ_ADDR_STATUS, r);
    `CHK(r[SSQ_ST_SEQ_DONE], 1'b0)
    for (int k = 0; k < 200 && s[SSQ_ST_SEQ_DONE] !== 1'b1; k++) begin
      rd_reg(SSQ_ADDR_STATUS, r);
      s = s | r;
    end
  endtask

  task automatic chk_order(input int cnt, input logic [31:0] e);
    `CHK(chq.size(), cnt)
    for (int i = 0; i < cnt && i < chq.size(); i++) `CHK(chq[i], e[4*i+:4])
  endtask

  task end_sim;
    if (n_fail == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // -------------------------------------------------------------------
  // Test sequence
  // -------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    rd_reg(SSQ_ADDR_CTRL, v);
    `CHK(v, SSQ_CTRL_RESET)
    `CHK(conv_power, 1'b1)
    rd_reg(SSQ_ADDR_HIGHLIM, v);
    `CHK(v, 32'h0000_ffff)
    rd_reg(8'hfc, v);
    `CHK(v, 32'h0000_0000)
    wr_reg(SSQ_ADDR_LOWLIM, 32'h0000_0123);
    wr_reg(SSQ_ADDR_HIGHLIM, 32'h0000_0abc);
    rd_reg(SSQ_ADDR_LOWLIM, v);
    `CHK(v, 32'h0000_0123)
    rd_reg(SSQ_ADDR_HIGHLIM, v);
    `CHK(v, 32'h0000_0abc)
    wr_reg(SSQ_ADDR_LIMMASK, 32'h0000_0000);
    wr_reg(SSQ_ADDR_EVENTS, 32'hffff_ffff);
    // Triggered scan; mask bit 8 must not pull in the injection channel.
    wr_reg(SSQ_ADDR_CTRL, 32'h0000_0007);
    wr_reg(SSQ_ADDR_CHMASK, 32'h0000_0103);
    e0 = n_eoc;
    scan(1'b0, st);
    `CHK(st[SSQ_ST_SEQ_DONE], 1'b1)
    chk_order(2, 32'h0000_0010);
    `CHK(n_eoc - e0, 1)
    rd_reg(SSQ_ADDR_RESULT0, v);
    `CHK(v, 32'h0000_0120)
    rd_reg(SSQ_ADDR_RESULT0 + 8'h04, v);
    `CHK(v, 32'hffff_ff80)
    rd_reg(SSQ_ADDR_STATUS, v);
    `CHK(v[SSQ_ST_SEQ_DONE], 1'b0)
    repeat (60) @(posedge clock);
    `CHK(chq.size(), 2)
    // One-shot injection.
    wr_reg(SSQ_ADDR_CMD, 32'h1 << SSQ_CMD_INJECT);
    rd_reg(SSQ_ADDR_STATUS, v);
    `CHK(v[SSQ_ST_INJ_ARMED], 1'b1)
    scan(1'b0, st);
    chk_order(3, 32'h0000_0810);
    `CHK(st[SSQ_ST_INJ_DONE], 1'b1)
    rd_reg(SSQ_ADDR_RESULT0 + 8'h20, v);
    `CHK(v, 32'h0000_0128)
    // Pin-started scan with the interrupt disabled.
    wr_reg(SSQ_ADDR_CTRL, 32'h0000_0005);
    e0 = n_eoc;
    scan(1'b1, st);
    `CHK(st[SSQ_ST_SEQ_DONE], 1'b1)
    chk_order(2, 32'h0000_0010);
    `CHK(n_eoc - e0, 0)
    // Saturation on channel 2, first masked, then allowed.
    wr_reg(SSQ_ADDR_CHMASK, 32'h0000_0004);
    wr_reg(SSQ_ADDR_SATMASK, 32'h0000_0000);
    scan(1'b0, st);
    `CHK(sat_irq, 1'b0)
    `CHK(limit_irq, 1'b0)
    wr_reg(SSQ_ADDR_SATMASK, 32'h0000_0004);
    wr_reg(SSQ_ADDR_LIMMASK, 32'h0000_0004);
    scan(1'b0, st);
    `CHK(sat_irq, 1'b1)
    `CHK(limit_irq, 1'b1)
    rd_reg(SSQ_ADDR_EVENTS, v);
    `CHK(v[18], 1'b1)
    `CHK(v[2], 1'b1)
    wr_reg(SSQ_ADDR_EVENTS, 32'hffff_ffff);
    // Averaged channel stays put and stores the sum.
    wr_reg(SSQ_ADDR_AVGMASK, 32'h0000_0001);
    wr_reg(SSQ_ADDR_CHMASK, 32'h0000_0001);
    scan(1'b0, st);
    chk_order(AVG, 32'h0000_0000);
    rd_reg(SSQ_ADDR_RESULT0, v);
    `CHK(v, AVG * 32'h0000_0120)
    wr_reg(SSQ_ADDR_AVGMASK, 32'h0000_0000);
    // Free-running, then a stop that lets the last conversion finish.
    wr_reg(SSQ_ADDR_CHMASK, 32'h0000_0003);
    wr_reg(SSQ_ADDR_CTRL, 32'h0000_0004);
    chq.delete();
    wr_reg(SSQ_ADDR_CMD, 32'h1 << SSQ_CMD_START);
    repeat (300) @(posedge clock);
    `CHK(chq.size() > 6, 1'b1)
    wr_reg(SSQ_ADDR_CMD, 32'h1 << SSQ_CMD_STOP);
    repeat (20) @(posedge clock);
    n = chq.size();
    repeat (100) @(posedge clock);
    `CHK(chq.size(), n)
    `CHK(n_done, n_start)
    // Block stop powers down and ignores a start.
    wr_reg(SSQ_ADDR_CTRL, 32'h0000_0000);
    repeat (2) @(posedge clock);
    `CHK(conv_power, 1'b0)
    wr_reg(SSQ_ADDR_CMD, 32'h1 << SSQ_CMD_START);
    repeat (50) @(posedge clock);
    `CHK(chq.size(), n)
    end_sim();
  end
endmodule
